// ---- rtl/agd_dig_out.sv ----
/*
 open-drain output stage for the digital output port.
 assumes a pull-up outside; the pin is only driven low.
*/
`timescale 1ns/1ps
module agd_dig_out #(
    parameter int width = 8
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [width-1:0] level_in,
    output logic [width-1:0] pin_out,
    output logic [width-1:0] pin_oe_out
);
    import agd_pkg::*;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_oe_out <= '0;
        end else begin
            pin_oe_out <= ~level_in;
        end
    end
    assign pin_out = '0;
endmodule

// ---- rtl/agd_pkg.sv ----
/*
 package for the acquisition gate digital i/o block: register map, fields, reset values.
 assumes a 32-bit avalon-mm slave with word addressing by byte address.
*/
package agd_pkg;
    localparam int agd_addr_width = 6;
    localparam logic [5:0] agd_ctrl_addr = 6'h00;
    localparam logic [5:0] agd_cmd_addr = 6'h04;
    localparam logic [5:0] agd_value_addr = 6'h08;
    localparam logic [5:0] agd_state_addr = 6'h0c;
    localparam logic [5:0] agd_irq_status_addr = 6'h10;
    localparam logic [5:0] agd_irq_mask_addr = 6'h14;
    localparam int agd_ctrl_status_mode = 0;
    localparam int agd_ctrl_stop_count_mode = 1;
    localparam int agd_ctrl_invert = 2;
    localparam int agd_ctrl_ext_trig_en = 3;
    localparam int agd_ctrl_gate_start = 4;
    localparam int agd_ctrl_clear_on_start = 5;
    localparam int agd_ctrl_drop_gate_on_stop = 6;
    localparam int agd_ctrl_group_stop = 7;
    localparam int agd_ctrl_gate_low_sw = 8;
    localparam int agd_ctrl_width = 9;
    localparam int agd_cmd_start = 0;
    localparam int agd_cmd_stop = 1;
    localparam int agd_cmd_preset = 2;
    localparam int agd_irq_started = 0;
    localparam int agd_irq_stopped = 1;
    localparam int agd_irq_preset = 2;
    localparam int agd_irq_width = 3;
    localparam logic [31:0] agd_unmapped_data = 32'h0000_0000;
    localparam logic [7:0] agd_value_reset = 8'h00;
    typedef enum logic [1:0] {agd_idle_type_s, agd_armed_s, agd_run_s} agd_state_type;
endpackage

// ---- rtl/agd_sync.sv ----
/*
 two-flop synchronisers and edge detectors for trigger and gate pins.
 assumes asynchronous pin inputs and one clock.
*/
`timescale 1ns/1ps
module agd_sync (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic trig_pin_in,
    input wire logic gate_pin_in,
    agd_sync_if.source sync_out
);
    import agd_pkg::*;
    logic [1:0] trig_sync;
    logic [1:0] gate_sync;
    logic trig_last;
    logic gate_last;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            trig_sync <= 2'h3;
            // gate line idles high on its pull-up
            gate_sync <= 2'h3;
        end else begin
            trig_sync <= {trig_sync[0], trig_pin_in};
            gate_sync <= {gate_sync[0], gate_pin_in};
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            trig_last <= 1'b1;
            gate_last <= 1'b1;
        end else begin
            trig_last <= trig_sync[1];
            gate_last <= gate_sync[1];
        end
    end

    assign sync_out.trig_level = trig_sync[1];
    assign sync_out.trig_fall = trig_last & ~trig_sync[1];
    assign sync_out.trig_rise = ~trig_last & trig_sync[1];
    assign sync_out.gate_level = gate_sync[1];
    assign sync_out.gate_fall = gate_last & ~gate_sync[1];
    assign sync_out.gate_rise = ~gate_last & gate_sync[1];
endmodule

// ---- rtl/agd_sync_if.sv ----
/*
 interface carrying synchronised trigger and gate levels and their edges.
 assumes producer and consumer share ref_clk_in.
*/
`timescale 1ns/1ps
interface agd_sync_if;
    logic trig_level;
    logic trig_fall;
    logic trig_rise;
    logic gate_level;
    logic gate_fall;
    logic gate_rise;
    modport source (output trig_level, trig_fall, trig_rise, gate_level, gate_fall, gate_rise);
    modport sink (input trig_level, trig_fall, trig_rise, gate_level, gate_fall, gate_rise);
endinterface

// ---- rtl/agd_top.sv ----
/*
 acquisition gate digital i/o: status / stop-count output, external trigger
 and gate start control, gate drop on preset stop, group stop, avalon-mm registers.
 assumes pins are asynchronous and a pull-up sits on each open-drain pin.
*/
`timescale 1ns/1ps
module agd_top #(
    parameter int value_width = 8
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [agd_pkg::agd_addr_width-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic external_trigger_input_in,
    input wire logic gate_pin_in,
    output logic gate_pin_out,
    output logic gate_pin_oe_out,
    input wire logic sweep_preset_in,
    input wire logic group_preset_in,
    output logic group_preset_out,
    output logic [value_width-1:0] dig_pin_out,
    output logic [value_width-1:0] dig_pin_oe_out,
    output logic acquire_enable_out,
    output logic clear_data_out,
    output logic irq_out
);
    import agd_pkg::*;

    agd_sync_if sync_bus ();
    agd_state_type state;
    agd_state_type next_state;
    logic [agd_ctrl_width-1:0] ctrl;
    logic [value_width-1:0] stop_count_output;
    logic [agd_irq_width-1:0] irq_status;
    logic [agd_irq_width-1:0] irq_mask;
    logic ack;
    logic wr_hit;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_preset;
    logic preset_hit;
    logic start_event;
    logic stop_event;
    logic ctrl_invert;
    logic trig_active;
    logic trig_start;
    logic trig_end;
    logic gate_forced_low;
    logic [value_width-1:0] out_level;
    logic [agd_irq_width-1:0] irq_set;

    function automatic logic [31:0] agd_merge(input logic [31:0] old_val,
            input logic [31:0] new_val, input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    agd_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .trig_pin_in(external_trigger_input_in),
        .gate_pin_in(gate_pin_in),
        .sync_out(sync_bus.source)
    );

    // one wait cycle per access, answer on the second edge
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_in | avs_write_in) & ~ack;
        end
    end
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
    assign wr_hit = avs_write_in & ack;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_readdata_out <= agd_unmapped_data;
        end else if (avs_read_in & ~ack) begin
            case (avs_address_in)
                agd_ctrl_addr: avs_readdata_out <= 32'(ctrl);
                agd_value_addr: avs_readdata_out <= 32'(stop_count_output);
                agd_state_addr: avs_readdata_out <= {29'h0, gate_forced_low,
                    state == agd_armed_s, state == agd_run_s};
                agd_irq_status_addr: avs_readdata_out <= 32'(irq_status);
                agd_irq_mask_addr: avs_readdata_out <= 32'(irq_mask);
                default: avs_readdata_out <= agd_unmapped_data;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl <= '0;
        end else if (wr_hit && avs_address_in == agd_ctrl_addr) begin
            ctrl <= agd_ctrl_width'(agd_merge(32'(ctrl), avs_writedata_in, avs_byteenable_in));
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_mask <= '0;
        end else if (wr_hit && avs_address_in == agd_irq_mask_addr && avs_byteenable_in[0]) begin
            irq_mask <= avs_writedata_in[agd_irq_width-1:0];
        end
    end

    assign cmd_start = wr_hit && avs_address_in == agd_cmd_addr && avs_byteenable_in[0]
        && avs_writedata_in[agd_cmd_start];
    assign cmd_stop = wr_hit && avs_address_in == agd_cmd_addr && avs_byteenable_in[0]
        && avs_writedata_in[agd_cmd_stop];
    assign cmd_preset = wr_hit && avs_address_in == agd_cmd_addr && avs_byteenable_in[0]
        && avs_writedata_in[agd_cmd_preset];

    assign ctrl_invert = ctrl[agd_ctrl_invert];
    // selected start source, active low after invert
    assign trig_active = ctrl[agd_ctrl_gate_start] ?
        (sync_bus.gate_level ~^ ctrl_invert) : (sync_bus.trig_level ~^ ctrl_invert);
    assign trig_start = ctrl[agd_ctrl_gate_start] ?
        (ctrl_invert ? sync_bus.gate_rise : sync_bus.gate_fall) :
        (ctrl_invert ? sync_bus.trig_rise : sync_bus.trig_fall);
    assign trig_end = ~trig_active;

    // group preset comes from another module through a pin
    logic [1:0] group_sync;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            group_sync <= 2'h0;
        end else begin
            group_sync <= {group_sync[0], group_preset_in};
        end
    end
    logic [1:0] preset_sync;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            preset_sync <= 2'h0;
        end else begin
            preset_sync <= {preset_sync[0], sweep_preset_in};
        end
    end
    logic preset_last;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            preset_last <= 1'b0;
        end else begin
            preset_last <= preset_sync[1];
        end
    end
    logic local_preset;
    assign local_preset = (preset_sync[1] & ~preset_last) | cmd_preset;
    assign preset_hit = local_preset | (ctrl[agd_ctrl_group_stop] & group_sync[1]);

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            group_preset_out <= 1'b0;
        end else begin
            group_preset_out <= ctrl[agd_ctrl_group_stop] & local_preset;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            agd_idle_type_s: begin
                if (cmd_start) begin
                    if (ctrl[agd_ctrl_ext_trig_en] | ctrl[agd_ctrl_gate_start]) begin
                        next_state = agd_armed_s;
                    end else begin
                        next_state = agd_run_s;
                    end
                end
            end
            agd_armed_s: begin
                if (cmd_stop) begin
                    next_state = agd_idle_type_s;
                end else if (trig_start) begin
                    next_state = agd_run_s;
                end
            end
            agd_run_s: begin
                if (cmd_stop) begin
                    next_state = agd_idle_type_s;
                end else if (preset_hit) begin
                    next_state = agd_idle_type_s;
                end else if ((ctrl[agd_ctrl_ext_trig_en] | ctrl[agd_ctrl_gate_start])
                        && trig_end) begin
                    next_state = agd_armed_s;
                end
            end
            default: next_state = agd_idle_type_s;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= agd_idle_type_s;
        end else begin
            state <= next_state;
        end
    end

    assign start_event = (state != agd_run_s) && (next_state == agd_run_s);
    assign stop_event = (state == agd_run_s) && (next_state != agd_run_s);

    // clear pulse one cycle before acquisition enable rises
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clear_data_out <= 1'b0;
        end else begin
            clear_data_out <= start_event & ((state == agd_armed_s)
                | ctrl[agd_ctrl_clear_on_start]);
        end
    end

    logic running_q;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            running_q <= 1'b0;
        end else begin
            running_q <= (state == agd_run_s);
        end
    end

    // events only while gate open
    assign acquire_enable_out = running_q & (state == agd_run_s) & sync_bus.gate_level
        & ~gate_forced_low;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gate_forced_low <= 1'b0;
        end else if (start_event) begin
            gate_forced_low <= 1'b0;
        end else if (stop_event && preset_hit && ctrl[agd_ctrl_drop_gate_on_stop]) begin
            gate_forced_low <= 1'b1;
        end
    end
    assign gate_pin_out = 1'b0;
    assign gate_pin_oe_out = gate_forced_low | ctrl[agd_ctrl_gate_low_sw];

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stop_count_output <= agd_value_reset;
        end else if (stop_event && ctrl[agd_ctrl_stop_count_mode]) begin
            stop_count_output <= stop_count_output + 1'b1;
        end else if (wr_hit && avs_address_in == agd_value_addr && avs_byteenable_in[0]) begin
            stop_count_output <= avs_writedata_in[value_width-1:0];
        end
    end

    always_comb begin
        out_level = '0;
        if (ctrl[agd_ctrl_stop_count_mode]) begin
            out_level = stop_count_output;
        end else if (ctrl[agd_ctrl_status_mode]) begin
            out_level = {value_width{state == agd_run_s}};
        end
        if (ctrl_invert) begin
            out_level = ~out_level;
        end
    end

    agd_dig_out #(.width(value_width)) u_dig_out (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .level_in(out_level),
        .pin_out(dig_pin_out),
        .pin_oe_out(dig_pin_oe_out)
    );

    assign irq_set = {preset_hit & stop_event, stop_event, start_event};
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_status <= '0;
        end else if (wr_hit && avs_address_in == agd_irq_status_addr && avs_byteenable_in[0]) begin
            irq_status <= (irq_status & ~avs_writedata_in[agd_irq_width-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status & irq_mask);
        end
    end
endmodule

// ---- verification/agd_far_model.sv ----
/*
 far-side model: trigger pin, gate line with pull-up, preset lines.
 assumes the bench calls drive just after a clock edge.
*/
`timescale 1ns/1ps
module agd_far_model (
    input wire logic ref_clk_in,
    input wire logic gate_oe_in,
    output logic trig_out,
    output logic gate_out,
    output logic sweep_out,
    output logic group_out
);
    logic gate_drv = 1'b1;
    initial begin
        trig_out = 1'b1;
        sweep_out = 1'b0;
        group_out = 1'b0;
    end
    // pull-up unless the block or the far side pulls low
    assign gate_out = gate_drv & ~gate_oe_in;
    task automatic drive(input logic t, input logic g, input logic s, input logic p);
        @(posedge ref_clk_in);
        trig_out <= t;
        gate_drv <= g;
        sweep_out <= s;
        group_out <= p;
    endtask
endmodule

// ---- verification/agd_top_assertions.sv ----
/*
 checker for the acquisition gate block, bound to agd_top.
 assumes only the top-level ports are visible.
*/
`timescale 1ns/1ps
module agd_top_assertions #(
    parameter int value_width = 8
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [agd_pkg::agd_addr_width-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic external_trigger_input_in,
    input wire logic gate_pin_in,
    input wire logic gate_pin_out,
    input wire logic [value_width-1:0] dig_pin_out,
    input wire logic acquire_enable_out,
    input wire logic clear_data_out,
    input wire logic group_preset_out,
    input wire logic irq_out
);
    import agd_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    AST_OD_LOW: assert property (gate_pin_out == 1'b0 && dig_pin_out == '0)
        else $error("open-drain pin driven high");
    AST_WAIT_FIRST: assert property ($rose(avs_read_in | avs_write_in) |-> avs_waitrequest_out)
        else $error("no wait cycle on new access");
    AST_WAIT_SECOND: assert property ((avs_read_in | avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out)
        else $error("access not answered in second cycle");
    AST_UNMAPPED_ZERO: assert property (avs_read_in && !avs_waitrequest_out &&
        (avs_address_in > 6'h14 || avs_address_in == agd_cmd_addr) |-> avs_readdata_out == '0)
        else $error("unmapped read not zero");
    AST_CLEAR_PULSE: assert property (clear_data_out |=> !clear_data_out)
        else $error("clear pulse longer than one cycle");
    AST_CLEAR_FIRST: assert property (clear_data_out |-> !acquire_enable_out)
        else $error("acquisition before clear");
    AST_GROUP_PULSE: assert property (group_preset_out |=> !group_preset_out)
        else $error("group stop pulse too long");
    AST_GATE_BLOCKS: assert property ((!gate_pin_in) [*4] |-> !acquire_enable_out)
        else $error("acquiring with gate closed");
    AST_TRIG_SYNC: assert property ($fell(external_trigger_input_in)
        |-> !clear_data_out ##1 !clear_data_out)
        else $error("trigger acted without synchroniser delay");
    COV_CLEAR: cover property (clear_data_out);
    COV_GROUP: cover property (group_preset_out);
    COV_IRQ: cover property (irq_out);
endmodule
bind agd_top agd_top_assertions #(.value_width(value_width)) u_chk (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .external_trigger_input_in(external_trigger_input_in), .gate_pin_in(gate_pin_in),
    .gate_pin_out(gate_pin_out), .dig_pin_out(dig_pin_out),
    .acquire_enable_out(acquire_enable_out), .clear_data_out(clear_data_out),
    .group_preset_out(group_preset_out), .irq_out(irq_out));

// ---- verification/tb.sv ----
/*
 testbench for agd_top: register sequences with expected pin levels.
 assumes the far-side model supplies trigger, gate and presets.
*/
`timescale 1ns/1ps
module tb;
    import agd_pkg::*;
    logic clk, rst_n, rd, wr, wait_s, wait_s_raw, trig, gate, sweep, grp, acq, clr, gpo, irq;
    logic [5:0] addr;
    logic [31:0] wd, rdata, data_s, q;
    logic gate_oe, s0;
    logic [7:0] dig_oe, ev;
    int fails, compares, i, n, gp_cnt;
    agd_top dut (.ref_clk_in(clk), .reset_n_in(rst_n), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_s_raw),
        .external_trigger_input_in(trig), .gate_pin_in(gate), .gate_pin_out(),
        .gate_pin_oe_out(gate_oe), .sweep_preset_in(sweep), .group_preset_in(grp),
        .group_preset_out(gpo), .dig_pin_out(), .dig_pin_oe_out(dig_oe),
        .acquire_enable_out(acq), .clear_data_out(clr), .irq_out(irq));
    agd_far_model far (.ref_clk_in(clk), .gate_oe_in(gate_oe), .trig_out(trig),
        .gate_out(gate), .sweep_out(sweep), .group_out(grp));
    always #2.5 clk = ~clk;
    // values seen half a cycle before each sampling edge
    always @(negedge clk) begin
        wait_s = wait_s_raw;
        data_s = rdata;
        if (gpo === 1'b1) gp_cnt++;
    end
    task automatic test_done;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wd <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wait_s !== 1'b0 && k < 20);
        if (wait_s !== 1'b0) begin
            fails++;
            test_done();
        end
        q = data_s;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wclr(input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (clr !== 1'b1 && n < lim);
    endtask
    function automatic logic [31:0] b(input int k);
        return 32'h1 << k;
    endfunction
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        addr = '0;
        rd = 1'b0;
        wr = 1'b0;
        wd = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle(1);
        chk(dig_oe, 8'hff);
        bus(0, agd_value_addr, 0);
        chk(q, agd_value_reset);
        bus(1, agd_ctrl_addr, b(agd_ctrl_status_mode));
        bus(1, agd_cmd_addr, b(agd_cmd_start));
        settle(3);
        chk(dig_oe, 8'h00);
        chk(acq, 1'b1);
        far.drive(1, 0, 0, 0);
        settle(4);
        chk(acq, 1'b0);
        far.drive(1, 1, 0, 0);
        bus(1, agd_ctrl_addr, b(agd_ctrl_status_mode) | b(agd_ctrl_invert));
        settle(1);
        chk(dig_oe, 8'hff);
        bus(1, agd_cmd_addr, b(agd_cmd_stop));
        settle(2);
        chk(dig_oe, 8'h00);
        bus(1, agd_value_addr, 32'hfe);
        bus(1, agd_ctrl_addr, b(agd_ctrl_stop_count_mode));
        settle(2);
        chk(dig_oe, 8'h01);
        for (i = 0; i < 2; i++) begin
            bus(1, agd_cmd_addr, b(agd_cmd_start));
            bus(1, agd_cmd_addr, b(agd_cmd_stop));
            settle(2);
            ev = ~(8'hfe + 8'(i + 1));
            chk(dig_oe, ev);
        end
        bus(1, agd_ctrl_addr, b(agd_ctrl_status_mode) | b(agd_ctrl_ext_trig_en));
        bus(1, agd_cmd_addr, b(agd_cmd_start));
        settle(4);
        bus(0, agd_state_addr, 0);
        chk(q, 32'h2);
        chk(acq, 1'b0);
        for (i = 0; i < 2; i++) begin
            far.drive(0, 1, 0, 0);
            wclr(12);
            chk(n >= 4 && n < 12, 1'b1);
            @(negedge clk);
            chk(acq, 1'b1);
            far.drive(1, 1, 0, 0);
            settle(5);
            bus(0, agd_state_addr, 0);
            chk(q, 32'h2);
        end
        bus(1, agd_cmd_addr, b(agd_cmd_stop));
        far.drive(0, 1, 0, 0);
        wclr(12);
        chk(n, 12);
        far.drive(1, 1, 0, 0);
        bus(1, agd_ctrl_addr, b(agd_ctrl_gate_start));
        bus(1, agd_cmd_addr, b(agd_cmd_start));
        far.drive(1, 0, 0, 0);
        wclr(12);
        chk(n < 12, 1'b1);
        @(negedge clk);
        chk(acq, 1'b0);
        far.drive(1, 1, 0, 0);
        settle(5);
        bus(0, agd_state_addr, 0);
        chk(q, 32'h2);
        bus(1, agd_cmd_addr, b(agd_cmd_stop));
        bus(1, agd_ctrl_addr, b(agd_ctrl_clear_on_start));
        bus(1, agd_cmd_addr, b(agd_cmd_start));
        wclr(8);
        chk(n < 8, 1'b1);
        bus(1, agd_cmd_addr, b(agd_cmd_stop));
        bus(1, agd_ctrl_addr, b(agd_ctrl_drop_gate_on_stop) | b(agd_ctrl_group_stop));
        bus(1, agd_irq_status_addr, 32'h7);
        bus(1, agd_cmd_addr, b(agd_cmd_start));
        far.drive(1, 1, 1, 0);
        settle(6);
        chk(gate_oe, 1'b1);
        chk(gp_cnt, 1);
        bus(0, agd_state_addr, 0);
        chk(q[2:0], 3'b100);
        bus(0, agd_irq_status_addr, 0);
        chk(q[agd_irq_preset], 1'b1);
        bus(1, agd_irq_mask_addr, 32'h0);
        settle(1);
        s0 = irq;
        chk(s0, 1'b0);
        bus(1, agd_irq_mask_addr, 32'h7);
        settle(1);
        chk(irq, 1'b1);
        bus(1, agd_irq_status_addr, 32'h7);
        bus(0, agd_irq_status_addr, 0);
        chk(q, 32'h0);
        settle(1);
        chk(irq, 1'b0);
        far.drive(1, 1, 0, 0);
        bus(1, agd_ctrl_addr, b(agd_ctrl_group_stop) | b(agd_ctrl_gate_low_sw));
        bus(1, agd_cmd_addr, b(agd_cmd_start));
        far.drive(1, 1, 0, 1);
        settle(5);
        bus(0, agd_state_addr, 0);
        chk(q[0], 1'b0);
        chk(gate_oe, 1'b1);
        bus(0, 6'h3c, 0);
        chk(q, agd_unmapped_data);
        bus(0, agd_cmd_addr, 0);
        chk(q, 32'h0);
        test_done();
    end
endmodule
